//--- hdl/cal_err_pkg.sv
package cal_err_pkg;

  // error code width and the "no error" answer to an empty queue
  localparam int         CODE_W        = 10;
  localparam int         MSG_W         = 7;
  localparam logic [9:0] CODE_NONE     = 10'h000;

  // calibration error code groups (decimal values shown at the right)
  localparam logic [9:0] CODE_A_FIRST  = 10'h190; // 400, dc volts
  localparam logic [9:0] CODE_A_LAST   = 10'h1A9; // 425, ohms and dc amps
  localparam logic [9:0] CODE_B_FIRST  = 10'h1B6; // 438, cal date missing
  localparam logic [9:0] CODE_B_LAST   = 10'h1B8; // 440
  localparam logic [9:0] CODE_C_FIRST  = 10'h1C2; // 450, ac group
  localparam logic [9:0] CODE_C_LAST   = 10'h1E7; // 487, incl 1 A zero at 478
  localparam logic [9:0] CODE_FRONT_REAR = 10'h1EA; // 490
  localparam logic [9:0] CODE_DATA_BAD = 10'h1F4; // 500
  localparam logic [9:0] CODE_D_FIRST  = 10'h201; // 513, data lost group
  localparam logic [9:0] CODE_D_LAST   = 10'h203; // 515
  localparam logic [9:0] CODE_QUESTION = 10'h262; // 610

  // message index bases, one message per code in table order
  localparam logic [6:0] MSG_A_BASE    = 7'h00;
  localparam logic [6:0] MSG_B_BASE    = 7'h1A;
  localparam logic [6:0] MSG_C_BASE    = 7'h1D;
  localparam logic [6:0] MSG_FRONT_REAR = 7'h43;
  localparam logic [6:0] MSG_DATA_BAD  = 7'h44;
  localparam logic [6:0] MSG_D_BASE    = 7'h45;
  localparam logic [6:0] MSG_QUESTION  = 7'h48;
  localparam logic [6:0] MSG_NONE      = 7'h7F;

  // status byte and event register bit positions
  localparam int         STB_EAV_BIT   = 2;
  localparam int         STB_RQS_BIT   = 6;
  localparam int         ESR_DEV_ERR_BIT = 3;
  localparam logic [7:0] SRE_RESET     = 8'h00;
  localparam logic [7:0] ESR_RESET     = 8'h00;

  // manufacturing step parameters: 1 V nominal, 1E3 Hz
  localparam int         PARAM_W       = 16;
  localparam logic [15:0] AC_LOW_PARAM = 16'h0001;
  localparam logic [15:0] AC_MID_PARAM = 16'h03E8;

  localparam int         QUEUE_DEPTH   = 10;

  typedef enum logic [1:0] {
    STEP_AC_LOW  = 2'b00,
    STEP_AC_MID  = 2'b01,
    STEP_REAR    = 2'b10,
    STEP_NONE    = 2'b11
  } step_e;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_BUSY = 1'b1
  } seq_e;

endpackage : cal_err_pkg

//--- hdl/cal_err_fifo.sv
`timescale 1ns/100ps
module cal_err_fifo #(
  parameter int W = 10,
  parameter int D = 10
) (
  input  wire logic         clk_in,     // system clock
  input  wire logic         rst_n_in,   // synchronised reset
  input  wire logic         push_in,    // write one entry
  input  wire logic [W-1:0] data_in,    // entry to write
  input  wire logic         pop_in,     // drop head entry
  input  wire logic         flush_in,   // discard everything
  output logic      [W-1:0] head_out,   // oldest entry
  output logic              empty_out,  // nothing held
  output logic              full_out    // no room
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [AW-1:0] LAST_SLOT = AW'(D - 1);
  localparam logic [CW-1:0] FULL_CNT  = CW'(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic          do_push;
  logic          do_pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST_SLOT) ? '0 : p + AW'(1);
  endfunction : bump

  assign empty_out = (count == '0);
  assign full_out  = (count == FULL_CNT);
  assign head_out  = mem[rd_ptr];

  // a full queue drops new entries rather than overwriting old ones
  always_comb begin
    do_pop      = pop_in && !empty_out && !flush_in;
    do_push     = push_in && (!full_out || do_pop || flush_in);
    next_wr_ptr = do_push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = do_pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count;
    if (flush_in) begin
      next_rd_ptr = wr_ptr;
      next_count  = do_push ? CW'(1) : '0;
    end else if (do_push && !do_pop) begin
      next_count = count + CW'(1);
    end else if (do_pop && !do_push) begin
      next_count = count - CW'(1);
    end
  end

  // pointer and count registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage carries no reset
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= data_in;
    end
  end

endmodule : cal_err_fifo

//--- hdl/cal_error_status_reporting.sv
// Overview of operation
// - low ac step takes param 1, mid ac step takes param 1E3
// - dc voltage failures reported as codes 400 to 405
// - dc current failures 421 to 425, 1 A zero as 478
// - ac failures reported as codes 450 to 473
// - missing cal date 438, missing next cal date 439
// - invalid data 500, lost ac, dc, dates 513 to 515
// - wrong front/rear selection 490, questionable calibration 610
// - every calibration error sets event status bit 3
// - every calibration error enters the common error queue unless it is full
// - error query answers with code and matching message
// - error-available bit 2 set while queue holds an entry
// - host tests bit 2; reading errors clears the flag
// - mask value 4 raises service request on error-available
`timescale 1ns/100ps
module cal_error_status_reporting
  import cal_err_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  input  wire logic                        clk_in,             // 100 MHz clock
  input  wire logic                        arst_n_in,          // async reset, low
  input  wire logic                        step_req_in,        // step command strobe
  input  wire cal_err_pkg::step_e          step_sel_in,        // which step
  input  wire logic [cal_err_pkg::PARAM_W-1:0] step_param_in,  // step parameter
  input  wire logic                        rear_selected_in,   // rear inputs chosen
  input  wire logic                        step_done_in,       // step finished
  input  wire logic                        cal_err_valid_in,   // cal error strobe
  input  wire logic [cal_err_pkg::CODE_W-1:0] cal_err_code_in, // cal error code
  input  wire logic                        err_query_in,       // error query strobe
  input  wire logic                        sre_write_in,       // load request mask
  input  wire logic [7:0]                  sre_value_in,       // request mask value
  input  wire logic                        esr_read_in,        // read-clear events
  input  wire logic                        clear_status_in,    // clear status, queue
  output logic                             step_start_out,     // step launched pulse
  output cal_err_pkg::step_e               step_id_out,        // launched step
  output logic                             step_reject_out,    // step refused pulse
  output logic                             busy_out,           // step in progress
  output logic                             err_resp_valid_out, // query answer pulse
  output logic [cal_err_pkg::CODE_W-1:0]   err_resp_code_out,  // answered code
  output logic [cal_err_pkg::MSG_W-1:0]    err_resp_msg_out,   // message index
  output logic [7:0]                       stb_out,            // status byte
  output logic [7:0]                       esr_out,            // event status
  output logic                             srq_out             // service request
);
  import cal_err_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta;
  logic rst_n;

  // release through two flops, assert at once
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // code table lookup

  // returns the message index, or MSG_NONE for a code outside the table
  function automatic logic [MSG_W-1:0] msg_of(input logic [CODE_W-1:0] c);
    logic [CODE_W-1:0] off;
    off    = '0;
    msg_of = MSG_NONE;
    if (c >= CODE_A_FIRST && c <= CODE_A_LAST) begin
      off    = c - CODE_A_FIRST;
      msg_of = MSG_A_BASE + off[MSG_W-1:0];
    end else if (c >= CODE_B_FIRST && c <= CODE_B_LAST) begin
      off    = c - CODE_B_FIRST;
      msg_of = MSG_B_BASE + off[MSG_W-1:0];
    end else if (c >= CODE_C_FIRST && c <= CODE_C_LAST) begin
      off    = c - CODE_C_FIRST;
      msg_of = MSG_C_BASE + off[MSG_W-1:0];
    end else if (c == CODE_FRONT_REAR) begin
      msg_of = MSG_FRONT_REAR;
    end else if (c == CODE_DATA_BAD) begin
      msg_of = MSG_DATA_BAD;
    end else if (c >= CODE_D_FIRST && c <= CODE_D_LAST) begin
      off    = c - CODE_D_FIRST;
      msg_of = MSG_D_BASE + off[MSG_W-1:0];
    end else if (c == CODE_QUESTION) begin
      msg_of = MSG_QUESTION;
    end
  endfunction : msg_of

  //////////////////////////////////////////////////////////////////////////////
  // error queue

  logic              push;
  logic [CODE_W-1:0] push_code;
  logic              q_pop;
  logic [CODE_W-1:0] q_head;
  logic              q_empty;
  logic              ext_ok;
  logic              fr_pending;
  logic              next_fr_pending;
  logic              fr_raise;

  // one push a cycle; an internal front/rear error waits behind an external one
  always_comb begin
    ext_ok    = cal_err_valid_in && (msg_of(cal_err_code_in) != MSG_NONE);
    push      = ext_ok || fr_pending;
    push_code = ext_ok ? cal_err_code_in : CODE_FRONT_REAR;
    q_pop     = err_query_in && !q_empty;
    next_fr_pending = fr_raise || (fr_pending && ext_ok);
  end

  cal_err_fifo #(
    .W (CODE_W),
    .D (DEPTH)
  ) u_queue (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n),
    .push_in   (push),
    .data_in   (push_code),
    .pop_in    (q_pop),
    .flush_in  (clear_status_in),
    .head_out  (q_head),
    .empty_out (q_empty),
    .full_out  ()
  );

  //////////////////////////////////////////////////////////////////////////////
  // step sequencer

  seq_e  seq;
  seq_e  next_seq;
  logic  next_step_start;
  step_e next_step_id;
  logic  next_step_reject;
  logic  step_ok;

  // a step arriving while another runs is refused, not queued
  always_comb begin
    next_seq         = seq;
    next_step_start  = 1'b0;
    next_step_id     = step_id_out;
    next_step_reject = 1'b0;
    fr_raise         = 1'b0;
    case (step_sel_in)
      STEP_AC_LOW: step_ok = (step_param_in == AC_LOW_PARAM);
      STEP_AC_MID: step_ok = (step_param_in == AC_MID_PARAM);
      STEP_REAR:   step_ok = rear_selected_in;
      default:     step_ok = 1'b0;
    endcase
    case (seq)
      SEQ_IDLE: begin
        if (step_req_in) begin
          if (step_ok) begin
            next_seq        = SEQ_BUSY;
            next_step_start = 1'b1;
            next_step_id    = step_sel_in;
          end else begin
            next_step_reject = 1'b1;
            fr_raise = (step_sel_in == STEP_REAR);
          end
        end
      end
      SEQ_BUSY: begin
        next_step_reject = step_req_in;
        if (step_done_in) begin
          next_seq = SEQ_IDLE;
        end
      end
      default: next_seq = SEQ_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      seq             <= SEQ_IDLE;
      step_start_out  <= 1'b0;
      step_id_out     <= STEP_NONE;
      step_reject_out <= 1'b0;
      fr_pending      <= 1'b0;
    end else begin
      seq             <= next_seq;
      step_start_out  <= next_step_start;
      step_id_out     <= next_step_id;
      step_reject_out <= next_step_reject;
      fr_pending      <= next_fr_pending;
    end
  end

  assign busy_out = (seq == SEQ_BUSY);

  //////////////////////////////////////////////////////////////////////////////
  // query answer and status

  logic              next_resp_valid;
  logic [CODE_W-1:0] next_resp_code;
  logic [MSG_W-1:0]  next_resp_msg;
  logic [7:0]        sre;
  logic [7:0]        next_sre;
  logic [7:0]        next_esr;
  logic [7:0]        next_stb;
  logic              next_srq;
  logic [7:0]        stb_core;

  // status byte follows the queue one edge later; set beats clear in esr
  always_comb begin
    next_resp_valid = err_query_in;
    next_resp_code  = err_resp_code_out;
    next_resp_msg   = err_resp_msg_out;
    if (err_query_in) begin
      next_resp_code = q_empty ? CODE_NONE : q_head;
      next_resp_msg  = q_empty ? MSG_NONE : msg_of(q_head);
    end
    next_sre = sre_write_in ? sre_value_in : sre;
    next_esr = (esr_read_in || clear_status_in) ? ESR_RESET : esr_out;
    if (push) begin
      next_esr[ESR_DEV_ERR_BIT] = 1'b1;
    end
    stb_core              = 8'h00;
    stb_core[STB_EAV_BIT] = !q_empty;
    next_srq              = |(stb_core & sre);
    next_stb              = stb_core;
    next_stb[STB_RQS_BIT] = next_srq;
  end

  // answer and status registers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      err_resp_valid_out <= 1'b0;
      err_resp_code_out  <= CODE_NONE;
      err_resp_msg_out   <= MSG_NONE;
      sre                <= SRE_RESET;
      esr_out            <= ESR_RESET;
      stb_out            <= 8'h00;
      srq_out            <= 1'b0;
    end else begin
      err_resp_valid_out <= next_resp_valid;
      err_resp_code_out  <= next_resp_code;
      err_resp_msg_out   <= next_resp_msg;
      sre                <= next_sre;
      esr_out            <= next_esr;
      stb_out            <= next_stb;
      srq_out            <= next_srq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_eav_follows_queue: assert property (@(posedge clk_in) disable iff (!rst_n)
    stb_out[STB_EAV_BIT] == !$past(q_empty))
    else $error("eav bit does not follow queue");

  a_esr_on_error: assert property (@(posedge clk_in) disable iff (!rst_n)
    push |=> esr_out[ESR_DEV_ERR_BIT])
    else $error("queued error did not set event bit 3");

  a_srq_raise: assert property (@(posedge clk_in) disable iff (!rst_n)
    (sre == 8'h04 && !q_empty) |=> srq_out)
    else $error("service request not raised");

  a_srq_release: assert property (@(posedge clk_in) disable iff (!rst_n)
    (q_empty || !sre[STB_EAV_BIT]) |=> !srq_out)
    else $error("service request held without cause");

  a_query_answer: assert property (@(posedge clk_in) disable iff (!rst_n)
    (err_query_in && !q_empty) |=> err_resp_valid_out
      && err_resp_code_out == $past(q_head) && err_resp_msg_out != MSG_NONE)
    else $error("query answer wrong");

  a_flag_clears_on_read: assert property (@(posedge clk_in) disable iff (!rst_n)
    (err_query_in && !q_empty && !push && !clear_status_in) ##1 q_empty
      |=> !stb_out[STB_EAV_BIT])
    else $error("eav stayed set after last read");

  a_bad_param_reject: assert property (@(posedge clk_in) disable iff (!rst_n)
    (seq == SEQ_IDLE && step_req_in && step_sel_in == STEP_AC_MID
      && step_param_in != AC_MID_PARAM) |=> (step_reject_out && !step_start_out))
    else $error("bad step parameter accepted");

  a_front_rear_code: assert property (@(posedge clk_in) disable iff (!rst_n)
    fr_raise |=> fr_pending ##[0:3] (push && push_code == CODE_FRONT_REAR))
    else $error("front/rear error not queued");

  a_bad_code_dropped: assert property (@(posedge clk_in) disable iff (!rst_n)
    (cal_err_valid_in && msg_of(cal_err_code_in) == MSG_NONE && !fr_pending) |-> !push)
    else $error("unknown code queued");

endmodule : cal_error_status_reporting

//--- dv/step_engine.sv
`timescale 1ns/100ps
module step_engine (
  input  wire logic       clk_in,    // bench clock
  input  wire logic       rst_n_in,  // reset, low
  input  wire logic       start_in,  // step launched
  input  wire logic [7:0] delay_in,  // cycles to finish
  output logic            done_out   // finish pulse
);
  logic [7:0] count;
  logic       run;

  ////////////////////////////////////////////////////////////////////////////
  // finish time set by delay_in, so a step can be held busy long enough
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count    <= 8'h00;
      run      <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        run   <= 1'b1;
        count <= delay_in;
      end else if (run) begin
        if (count == 8'h00) begin
          run      <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count <= count - 8'h01;
        end
      end
    end
  end
endmodule : step_engine

//--- dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import cal_err_pkg::*;
  localparam int DEPTH = 4;
  logic        clk_in, arst_n_in, step_req_in, rear_selected_in, step_done_in;
  logic        cal_err_valid_in, err_query_in, sre_write_in, esr_read_in;
  logic        clear_status_in, step_start_out, step_reject_out, busy_out;
  logic        err_resp_valid_out, srq_out;
  step_e       step_sel_in, step_id_out;
  logic [15:0] step_param_in;
  logic [9:0]  cal_err_code_in, err_resp_code_out;
  logic [6:0]  err_resp_msg_out;
  logic [7:0]  sre_value_in, stb_out, esr_out, delay;
  int          num_errors, n_compared;
  int          codes [18] = '{400, 405, 406, 420, 421, 425, 478, 450, 473,
                              438, 439, 440, 490, 500, 513, 514, 515, 610};

  cal_error_status_reporting #(.DEPTH(DEPTH)) dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .step_req_in(step_req_in),
    .step_sel_in(step_sel_in), .step_param_in(step_param_in),
    .rear_selected_in(rear_selected_in), .step_done_in(step_done_in),
    .cal_err_valid_in(cal_err_valid_in), .cal_err_code_in(cal_err_code_in),
    .err_query_in(err_query_in), .sre_write_in(sre_write_in),
    .sre_value_in(sre_value_in), .esr_read_in(esr_read_in),
    .clear_status_in(clear_status_in), .step_start_out(step_start_out),
    .step_id_out(step_id_out), .step_reject_out(step_reject_out),
    .busy_out(busy_out), .err_resp_valid_out(err_resp_valid_out),
    .err_resp_code_out(err_resp_code_out), .err_resp_msg_out(err_resp_msg_out),
    .stb_out(stb_out), .esr_out(esr_out), .srq_out(srq_out));

  step_engine engine (.clk_in(clk_in), .rst_n_in(arst_n_in),
    .start_in(step_start_out), .delay_in(delay), .done_out(step_done_in));

  ////////////////////////////////////////////////////////////////////////////
  // helpers; inputs always move 1 ns after the rising edge
  task tick;
    @(posedge clk_in);
    #1;
  endtask : tick

  task tally_and_finish;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic probe(input int sel);
    case (sel)
      0: probe = step_start_out;
      1: probe = step_reject_out;
      2: probe = err_resp_valid_out;
      3: probe = esr_out[ESR_DEV_ERR_BIT];
      4: probe = stb_out[STB_EAV_BIT];
      5: probe = srq_out;
      default: probe = ~busy_out;
    endcase
  endfunction : probe

  // bounded wait; a hang ends the run as a failure
  task wait_hi(input int sel, input int lim);
    int i;
    for (i = 0; i < lim && probe(sel) !== 1'b1; i++) tick();
    if (probe(sel) !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected 1 on probe %0d", $time, probe(sel), sel);
      tally_and_finish();
    end
  endtask : wait_hi

  function automatic logic [6:0] msg_of(input int c);
    if (c <= 425) msg_of = MSG_A_BASE + 7'(c - 400);
    else if (c <= 440) msg_of = MSG_B_BASE + 7'(c - 438);
    else if (c <= 487) msg_of = MSG_C_BASE + 7'(c - 450);
    else if (c == 490) msg_of = MSG_FRONT_REAR;
    else if (c == 500) msg_of = MSG_DATA_BAD;
    else if (c <= 515) msg_of = MSG_D_BASE + 7'(c - 513);
    else msg_of = MSG_QUESTION;
  endfunction : msg_of

  task push(input logic [9:0] code);
    cal_err_valid_in = 1'b1;
    cal_err_code_in  = code;
    tick();
    cal_err_valid_in = 1'b0;
  endtask : push

  // ends one edge after the answer so the queue flag has settled
  task query(input logic [9:0] code, input logic [6:0] msg);
    err_query_in = 1'b1;
    tick();
    err_query_in = 1'b0;
    wait_hi(2, 4);
    check(err_resp_code_out, code);
    check(err_resp_msg_out, msg);
    tick();
  endtask : query

  task do_step(input step_e sel, input logic [15:0] prm, input logic ok);
    step_sel_in   = sel;
    step_param_in = prm;
    step_req_in   = 1'b1;
    tick();
    step_req_in = 1'b0;
    wait_hi(ok ? 0 : 1, 4);
    check(step_start_out, ok);
    if (ok) begin
      check(step_id_out, sel);
      check(busy_out, 1'b1);
    end
    tick();
  endtask : do_step

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_reset;
    check(stb_out, 8'h00);
    check(esr_out, ESR_RESET);
    check(srq_out, 1'b0);
    check(step_id_out, STEP_NONE);
    query(CODE_NONE, MSG_NONE);
  endtask : t_reset

  // factory-only steps; rear short fitted, rear step refused before rear inputs are chosen, then run with them
  task t_steps;
    do_step(STEP_AC_LOW, 16'h0002, 1'b0);
    do_step(STEP_AC_MID, 16'h03E7, 1'b0);
    do_step(STEP_NONE, 16'h0000, 1'b0);
    do_step(STEP_AC_LOW, AC_LOW_PARAM, 1'b1);
    do_step(STEP_AC_MID, AC_MID_PARAM, 1'b0);
    wait_hi(6, 40);
    do_step(STEP_AC_MID, AC_MID_PARAM, 1'b1);
    wait_hi(6, 40);
    rear_selected_in = 1'b0;
    do_step(STEP_REAR, 16'h0000, 1'b0);
    wait_hi(4, 6);
    query(CODE_FRONT_REAR, MSG_FRONT_REAR);
    rear_selected_in = 1'b1;
    do_step(STEP_REAR, 16'h0000, 1'b1);
    wait_hi(6, 40);
  endtask : t_steps

  // event register read-cleared first, so each set is seen fresh
  task t_codes;
    int i;
    for (i = 0; i < 18; i++) begin
      esr_read_in = 1'b1;
      tick();
      esr_read_in = 1'b0;
      tick();
      check(esr_out, 8'h00);
      push(codes[i][9:0]);
      wait_hi(3, 4);
      wait_hi(4, 4);
      query(codes[i][9:0], msg_of(codes[i]));
      check(stb_out[STB_EAV_BIT], 1'b0);
    end
  endtask : t_codes

  // an unknown code is ignored while there is room, then one past full is lost
  task t_fifo;
    int i;
    cal_err_valid_in = 1'b1;
    cal_err_code_in  = 10'h1AE;
    tick();
    for (i = 0; i < DEPTH + 1; i++) begin
      cal_err_code_in = CODE_A_FIRST + 10'(i);
      tick();
    end
    cal_err_valid_in = 1'b0;
    repeat (3) tick();
    for (i = 0; i < DEPTH; i++) begin
      check(stb_out[STB_EAV_BIT], 1'b1);
      query(CODE_A_FIRST + 10'(i), MSG_A_BASE + 7'(i));
    end
    check(stb_out[STB_EAV_BIT], 1'b0);
    query(CODE_NONE, MSG_NONE);
  endtask : t_fifo

  // error and event read in one cycle: the set must win
  task t_srq;
    sre_write_in = 1'b1;
    sre_value_in = 8'h04;
    tick();
    sre_write_in = 1'b0;
    push(CODE_QUESTION);
    wait_hi(5, 6);
    check(stb_out, 8'h44);
    query(CODE_QUESTION, MSG_QUESTION);
    check(srq_out, 1'b0);
    check(stb_out, 8'h00);
    sre_write_in = 1'b1;
    sre_value_in = SRE_RESET;
    tick();
    sre_write_in = 1'b0;
    esr_read_in  = 1'b1;
    push(CODE_DATA_BAD);
    esr_read_in  = 1'b0;
    wait_hi(4, 6);
    check(esr_out, 8'h08);
    tick();
    check(srq_out, 1'b0);
    clear_status_in = 1'b1;
    tick();
    clear_status_in = 1'b0;
    repeat (2) tick();
    check(stb_out, 8'h00);
    check(esr_out, 8'h00);
  endtask : t_srq

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    num_errors       = 0;
    n_compared       = 0;
    arst_n_in        = 1'b0;
    step_req_in      = 1'b0;
    step_sel_in      = STEP_NONE;
    step_param_in    = 16'h0000;
    rear_selected_in = 1'b0;
    cal_err_valid_in = 1'b0;
    cal_err_code_in  = 10'h000;
    err_query_in     = 1'b0;
    sre_write_in     = 1'b0;
    sre_value_in     = 8'h00;
    esr_read_in      = 1'b0;
    clear_status_in  = 1'b0;
    delay            = 8'h14;
    repeat (16) @(posedge clk_in);
    #1;
    arst_n_in = 1'b1;
    repeat (3) tick();
    t_reset();
    t_steps();
    t_codes();
    t_fifo();
    t_srq();
    tally_and_finish();
  end
endmodule : testbench
